// ---- logic/nsx_pkg.sv ----
// Package of encodings, field layouts and types for the nibble-swap/XOR/direction executor
package nsx_pkg;
    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int DEST_BIT = 7;
    localparam logic [5:0] OPC_SWAP = 6'h0E;
    localparam logic [5:0] OPC_XORF = 6'h06;
    localparam logic [5:0] OPC_XORL = 6'h3A;
    localparam logic [10:0] OPC_DIR = 11'h00C;
    localparam logic [2:0] DIR_SEL_MIN = 3'h5;
    localparam logic [2:0] DIR_SEL_MAX = 3'h7;
    localparam logic [6:0] DIR_FADDR_BASE = 7'h05;
    localparam logic [6:0] DIR_FADDR_BANK = 7'h00;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam int NUM_DIR = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        NSX_Q1 = 2'b00,
        NSX_Q2 = 2'b01,
        NSX_Q3 = 2'b10,
        NSX_Q4 = 2'b11
    } nsx_phase_t;

    typedef enum logic [2:0] {
        NSX_OP_NONE = 3'b000,
        NSX_OP_SWAP = 3'b001,
        NSX_OP_XORF = 3'b010,
        NSX_OP_XORL = 3'b011,
        NSX_OP_DIR = 3'b100
    } nsx_op_t;

    typedef struct packed {
        nsx_op_t op;
        logic toFile;
        logic [FADDR_W-1:0] faddr;
        logic [DATA_W-1:0] literal;
        logic [1:0] dirIdx;
    } nsx_dec_t;

    typedef struct packed {
        logic en;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } nsx_fwr_t;
endpackage

// ---- logic/nsx_decode.sv ----
// Combinational opcode decoder for the four supported instructions
`timescale 1ns/1ps
`default_nettype none
module nsx_decode
    import nsx_pkg::*;
(
    input wire logic [INSTR_W-1:0] instr,
    output nsx_dec_t dec
);
    logic [2:0] sel;
    always_comb begin
        sel = instr[2:0];
        dec = '0;
        dec.op = NSX_OP_NONE;
        dec.faddr = instr[FADDR_W-1:0];
        dec.toFile = instr[DEST_BIT];
        dec.literal = instr[DATA_W-1:0];
        dec.dirIdx = 2'(sel - DIR_SEL_MIN);
        if (instr[13:8] == OPC_SWAP) begin
            dec.op = NSX_OP_SWAP;
        end else if (instr[13:8] == OPC_XORF) begin
            dec.op = NSX_OP_XORF;
        end else if (instr[13:8] == OPC_XORL) begin
            dec.op = NSX_OP_XORL;
        end else if (instr[13:3] == OPC_DIR && sel >= DIR_SEL_MIN && sel <= DIR_SEL_MAX) begin
            dec.op = NSX_OP_DIR;
        end
    end
endmodule // nsx_decode
`default_nettype wire

// ---- logic/nsx_exec.sv ----
// Four-phase executor for nibble swap, XOR and direction-load instructions
`timescale 1ns/1ps
`default_nettype none
module nsx_exec
    import nsx_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic instrValid,
    output logic [FADDR_W-1:0] fileRdAddr,
    input wire logic [DATA_W-1:0] fileRdData,
    output nsx_fwr_t fileWr,
    input wire nsx_fwr_t busWr,
    input wire logic [FADDR_W-1:0] busRdAddr,
    output logic [DATA_W-1:0] busRdData,
    output logic busRdHit,
    output logic [DATA_W-1:0] wReg,
    output logic zeroFlag,
    output logic zeroWrEn,
    output logic [NUM_DIR*DATA_W-1:0] dirRegs,
    output nsx_phase_t phase,
    output logic done
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        nsx_phase_t phase;
        nsx_dec_t dec;
        logic [DATA_W-1:0] operand;
        logic [DATA_W-1:0] result;
        logic [DATA_W-1:0] w;
        logic zero;
        logic zeroWe;
        nsx_fwr_t fwr;
        logic done;
        logic [NUM_DIR-1:0][DATA_W-1:0] dir;
        logic [DATA_W-1:0] busRd;
    } nsx_state_t;

    nsx_state_t st_r;
    nsx_state_t st_nxt;
    nsx_dec_t decNow;
    logic [NUM_DIR-1:0] busDirHit;
    logic [NUM_DIR-1:0] rdDirHit;

    nsx_decode u_decode (
        .instr(instr),
        .dec(decNow)
    );

    // ------------------------------------------------------------
    // Direction register address match
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DIR; gi++) begin : g_dir
            assign busDirHit[gi] = busWr.en && busWr.addr == DIR_FADDR_BASE + 7'(gi);
            assign rdDirHit[gi] = busRdAddr == DIR_FADDR_BASE + 7'(gi);
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.zeroWe = 1'b0;
        st_nxt.fwr.en = 1'b0;
        st_nxt.busRd = '0;
        for (int i = 0; i < NUM_DIR; i++) begin
            if (busDirHit[i]) begin
                st_nxt.dir[i] = busWr.data;
            end
            if (rdDirHit[i]) begin
                st_nxt.busRd = st_r.dir[i];
            end
        end
        case (st_r.phase)
            NSX_Q1: begin
                st_nxt.dec = instrValid ? decNow : '0;
                st_nxt.phase = NSX_Q2;
            end
            NSX_Q2: begin
                st_nxt.operand = (st_r.dec.op == NSX_OP_XORL) ? st_r.dec.literal : fileRdData;
                st_nxt.phase = NSX_Q3;
            end
            NSX_Q3: begin
                case (st_r.dec.op)
                    NSX_OP_SWAP: st_nxt.result = {st_r.operand[3:0], st_r.operand[7:4]};
                    NSX_OP_XORF: st_nxt.result = st_r.w ^ st_r.operand;
                    NSX_OP_XORL: st_nxt.result = st_r.w ^ st_r.operand;
                    default: st_nxt.result = st_r.w;
                endcase
                st_nxt.phase = NSX_Q4;
            end
            NSX_Q4: begin
                case (st_r.dec.op)
                    NSX_OP_SWAP, NSX_OP_XORF: begin
                        if (st_r.dec.toFile) begin
                            st_nxt.fwr.en = 1'b1;
                            st_nxt.fwr.addr = st_r.dec.faddr;
                            st_nxt.fwr.data = st_r.result;
                        end else begin
                            st_nxt.w = st_r.result;
                        end
                    end
                    NSX_OP_XORL: st_nxt.w = st_r.result;
                    NSX_OP_DIR: st_nxt.dir[st_r.dec.dirIdx] = st_r.w;
                    default: ;
                endcase
                if (st_r.dec.op == NSX_OP_XORF || st_r.dec.op == NSX_OP_XORL) begin
                    st_nxt.zero = st_r.result == 8'h00;
                    st_nxt.zeroWe = 1'b1;
                end
                if (st_r.dec.toFile && st_r.dec.op == NSX_OP_XORF) begin
                    for (int i = 0; i < NUM_DIR; i++) begin
                        if (st_r.dec.faddr == DIR_FADDR_BASE + 7'(i)) begin
                            st_nxt.dir[i] = st_r.result;
                        end
                    end
                end
                if (st_r.dec.toFile && st_r.dec.op == NSX_OP_SWAP) begin
                    for (int i = 0; i < NUM_DIR; i++) begin
                        if (st_r.dec.faddr == DIR_FADDR_BASE + 7'(i)) begin
                            st_nxt.dir[i] = st_r.result;
                        end
                    end
                end
                st_nxt.done = st_r.dec.op != NSX_OP_NONE;
                st_nxt.phase = NSX_Q1;
            end
            default: st_nxt.phase = NSX_Q1;
        endcase
        if (!clkEn) begin
            st_nxt = st_r;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.phase <= NSX_Q1;
            st_r.w <= W_RESET;
            st_r.dir <= {NUM_DIR{DIR_RESET}};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign fileRdAddr = st_r.dec.faddr;
    assign fileWr = st_r.fwr;
    assign busRdData = st_r.busRd;
    assign busRdHit = |rdDirHit;
    assign wReg = st_r.w;
    assign zeroFlag = st_r.zero;
    assign zeroWrEn = st_r.zeroWe;
    assign dirRegs = st_r.dir;
    assign phase = st_r.phase;
    assign done = st_r.done;
endmodule // nsx_exec
`default_nettype wire

// ---- bench/nsx_exec_properties.sv ----
// Concurrent checks on the executor ports
`timescale 1ns/1ps
`default_nettype none
module nsx_exec_checker
    import nsx_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic instrValid,
    input wire logic [DATA_W-1:0] fileRdData,
    input wire nsx_fwr_t fileWr,
    input wire logic [DATA_W-1:0] wReg,
    input wire logic zeroFlag,
    input wire logic zeroWrEn,
    input wire nsx_phase_t phase,
    input wire logic done
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Instruction taken in Q1, then three more enabled phases
    // ------------------------------------------------------------
    sequence s_take(logic [5:0] op);
        phase == NSX_Q1 && clkEn && instrValid && instr[13:8] == op ##1 clkEn[*3];
    endsequence
    sequence s_dir;
        phase == NSX_Q1 && clkEn && instrValid && instr[13:3] == OPC_DIR
            && instr[2:0] >= DIR_SEL_MIN ##1 clkEn[*3];
    endsequence
    property p_xl;
        s_take(OPC_XORL) |=> wReg == ($past(wReg, 4) ^ $past(instr[7:0], 4));
    endproperty
    a_xl: assert property (p_xl) else $error("literal xor result wrong");
    property p_zf;
        s_take(OPC_XORL) |=> zeroWrEn && zeroFlag == ($past(wReg, 4) == $past(instr[7:0], 4));
    endproperty
    a_zf: assert property (p_zf) else $error("zero flag wrong");
    property p_sw;
        s_take(OPC_SWAP) |=> !zeroWrEn && ($past(instr[7], 4)
            || wReg == {$past(fileRdData[3:0], 3), $past(fileRdData[7:4], 3)});
    endproperty
    a_sw: assert property (p_sw) else $error("swap result wrong");
    property p_sf;
        s_take(OPC_XORF) |=> !$past(instr[7], 4)
            || fileWr.en && fileWr.data == ($past(wReg, 4) ^ $past(fileRdData, 3));
    endproperty
    a_sf: assert property (p_sf) else $error("register xor write wrong");
    property p_dr;
        s_dir |=> done && !zeroWrEn && !fileWr.en;
    endproperty
    a_dr: assert property (p_dr) else $error("direction load wrong");
    property p_ph;
        clkEn |=> phase == nsx_phase_t'($past(phase) + 2'h1);
    endproperty
    a_ph: assert property (p_ph) else $error("phase step wrong");
    property p_dn;
        done |-> $past(phase) == NSX_Q4 && phase == NSX_Q1;
    endproperty
    a_dn: assert property (p_dn) else $error("done out of place");
    property p_fw;
        fileWr.en |=> !fileWr.en;
    endproperty
    a_fw: assert property (p_fw) else $error("write pulse too long");
endmodule // nsx_exec_checker

bind nsx_exec nsx_exec_checker u_chk (.clock(clock), .rst(rst), .clkEn(clkEn),
    .instr(instr), .instrValid(instrValid), .fileRdData(fileRdData), .fileWr(fileWr),
    .wReg(wReg), .zeroFlag(zeroFlag), .zeroWrEn(zeroWrEn), .phase(phase), .done(done));
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s exp %0h got %0h", n, e, g); end end
module testbench
    import nsx_pkg::*;
;
    logic clock = 0, rst = 1, clkEn = 1, instrValid = 0, busRdHit, zeroFlag, zeroWrEn, done;
    logic [13:0] instr = '0;
    logic [6:0] fileRdAddr, busRdAddr = '0;
    logic [7:0] fileRdData, busRdData, wReg;
    logic [23:0] dirRegs;
    nsx_fwr_t fileWr, busWr = '0;
    nsx_phase_t phase;
    int mismatches = 0, check_count = 0, w = 0, z = 0;
    int fm[128];
    int dr[3] = '{255, 255, 255};
    logic [13:0] prog[] = '{14'h0E20, 14'h3AEF, 14'h3AAF, 14'h3AAF, 14'h06A1, 14'h3AB5,
        14'h0E85, 14'h0687, 14'h0606, 14'h0065, 14'h0066, 14'h0067, 14'h0064, 14'h0060,
        14'h3FFF, 14'h0EA1};
    always #10 clock = ~clock;
    assign fileRdData = 8'(fm[fileRdAddr]);
    nsx_exec DUT (.clock(clock), .rst(rst), .clkEn(clkEn), .instr(instr),
        .instrValid(instrValid), .fileRdAddr(fileRdAddr), .fileRdData(fileRdData),
        .fileWr(fileWr), .busWr(busWr), .busRdAddr(busRdAddr), .busRdData(busRdData),
        .busRdHit(busRdHit), .wReg(wReg), .zeroFlag(zeroFlag), .zeroWrEn(zeroWrEn),
        .dirRegs(dirRegs), .phase(phase), .done(done));
    task automatic close_out;
        if (mismatches == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic exec(input logic [13:0] i);
        int a, f, r, d, fw, zw, dn, rs;
        for (int k = 0; k < 8 && phase !== NSX_Q1; k++) @(negedge clock);
        if (phase !== NSX_Q1) begin
            mismatches++;
            close_out();
        end
        instr = i;
        instrValid = 1;
        @(posedge clock);
        @(negedge clock);
        instr = 14'($urandom);
        instrValid = 1'($urandom);
        @(posedge clock);
        @(negedge clock);
        instrValid = 0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        a = i[6:0]; f = fm[a]; d = i[7]; fw = 0; zw = 0; dn = 1; rs = 1; r = 0;
        if (i[13:8] == 6'h0E) r = {f[3:0], f[7:4]};
        else if (i[13:8] == 6'h06) begin r = w ^ f; zw = 1; end
        else if (i[13:8] == 6'h3A) begin r = w ^ i[7:0]; zw = 1; d = 0; end
        else if (i[13:3] == OPC_DIR && i[2:0] >= 5) begin dr[i[2:0] - 5] = w; fm[i[2:0]] = w; rs = 0; end
        else begin dn = 0; rs = 0; end
        if (rs && d == 0) w = r;
        if (rs && d == 1) begin fm[a] = r; fw = 1; if (a >= 5 && a <= 7) dr[a - 5] = r; end
        if (zw) z = (r == 0);
        `CHK("done", dn, done)
        `CHK("wReg", w, wReg)
        `CHK("fileWr.en", fw, fileWr.en)
        if (fw) `CHK("fileWr", {7'(a), 8'(r)}, {fileWr.addr, fileWr.data})
        `CHK("zeroWrEn", zw, zeroWrEn)
        `CHK("zeroFlag", z, zeroFlag)
        `CHK("dirRegs", {dr[2][7:0], dr[1][7:0], dr[0][7:0]}, dirRegs)
    endtask
    task automatic bus(input int a, input int v);
        @(negedge clock);
        busWr = '{1'b1, 7'(a), 8'(v)};
        busRdAddr = 7'(a);
        @(negedge clock);
        busWr.en = 0;
        if (a >= 5 && a <= 7) begin dr[a - 5] = v; fm[a] = v; end
        `CHK("busRdHit", a >= 5 && a <= 7, busRdHit)
        @(negedge clock);
        `CHK("busRdData", (a >= 5 && a <= 7) ? v : 0, busRdData)
    endtask
    task automatic stall;
        nsx_phase_t p;
        @(negedge clock);
        p = phase;
        clkEn = 0;
        repeat (3) @(negedge clock);
        `CHK("phase", p, phase)
        `CHK("wReg", w, wReg)
        `CHK("dirRegs", {dr[2][7:0], dr[1][7:0], dr[0][7:0]}, dirRegs)
        clkEn = 1;
    endtask
    initial begin
        void'($urandom(32'h21B3));
        foreach (fm[j]) fm[j] = $urandom % 256;
        fm[5] = 8'hFF; fm[6] = 8'hFF; fm[7] = 8'hFF; fm[32] = 8'hA5; fm[33] = 8'hAF;
        repeat (3) @(posedge clock);
        @(negedge clock);
        `CHK("dirRegs", 24'hFFFFFF, dirRegs)
        `CHK("wReg", 0, wReg)
        rst = 0;
        foreach (prog[j]) exec(prog[j]);
        for (int j = 0; j < 60; j++) begin
            case ($urandom % 5)
                0: exec({6'h0E, 8'($urandom)});
                1: exec({6'h06, 8'($urandom)});
                2: exec({6'h3A, 8'($urandom)});
                3: exec({OPC_DIR, 3'($urandom)});
                default: begin
                    bus($urandom % 9, $urandom % 256);
                    stall();
                end
            endcase
        end
        close_out();
    end
endmodule // testbench
`default_nettype wire
